// ===== hw/sleep_wake_pkg.sv
// Contract
// - Three wake sources, each selectable before sleep
// - Counter wakes only from light sleep
// - Counter wake select defaults on, 0x8
// - Select activity wakes either sleep, 0x4
// - Wake pin high long enough wakes, 0x2
// - Sleep entered only with allow bit 0x1
// - Option 0x1000 reloads regulator trim on wake
// - Option 0x0800 reloads detector microcode on wake
// - Option 0x0100 keeps sleep settings after wake
// - Option 0x0080 loads operating set, else default
// - Entry saves configuration to store, then sleeps
// - Option 0x0008 loads 64-bit unique id
// - Option 0x0002 enables receiver as final step
// - Option 0x0001 measures temperature, voltage; results held
// - Deep sleep reads return all ones
// - Wake raises reset output, init then idle
// - Wake starts oscillator, regulator after 4 ms
// - Init restores store, up to 40 us
// - Deep sleep keeps only store, waits event
package sleep_wake_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;          // System clock period
    localparam int WAKE_DELAY_MS = 4;           // Oscillator settle time
    localparam int WAKE_DELAY_CYCLES = WAKE_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int INIT_RESTORE_US = 40;        // Longest restore time
    localparam int INIT_CYCLES = INIT_RESTORE_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_PIN_MIN_NS = 1000;      // Wake pin qualify time
    localparam int WAKE_PIN_CYCLES = (WAKE_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;                // Shared timer width

    // ==========================================================
    // Wake source bits and their reset value
    typedef struct packed {
        logic wake_on_counter;                  // Weight 0x8
        logic wake_on_select;                   // Weight 0x4
        logic wake_on_pin;                      // Weight 0x2
        logic sleep_allow;                      // Weight 0x1
    } wake_cfg_s;
    localparam logic [3:0] WAKE_CFG_RESET = 4'h8;

    // ==========================================================
    // On-wake option bit positions
    localparam int MODE_W = 13;
    localparam int MODE_RELOAD_REGULATOR_TRIM = 12;   // 0x1000
    localparam int MODE_RELOAD_DETECTOR_CODE = 11;    // 0x0800
    localparam int MODE_KEEP_SLEEP_SETTINGS = 8;      // 0x0100
    localparam int MODE_RELOAD_OPERATING_SET = 7;     // 0x0080
    localparam int MODE_RESTORE_CONFIG = 6;           // 0x0040
    localparam int MODE_RELOAD_UNIQUE_ID = 3;         // 0x0008
    localparam int MODE_RECEIVE_AFTER_WAKE = 1;       // 0x0002
    localparam int MODE_MEASURE_AFTER_WAKE = 0;       // 0x0001
    localparam logic [12:0] MODE_RESET = 13'h0000;

    // ==========================================================
    // Wake-up action strobes
    typedef struct packed {
        logic trim;                             // Regulator trim reload
        logic detector;                         // Detector code reload
        logic opset;                            // Saved operating set load
        logic opset_default;                    // Operating set to default
        logic config_restore;                   // Store copied back
        logic unique_id;                        // Identifier loaded
        logic receive;                          // Receiver enable
        logic measure;                          // Conversion start
    } wake_act_s;

    // ==========================================================
    // Serial reply
    localparam logic [31:0] REPLY_ASLEEP = 32'hffffffff;
    localparam logic [31:0] REPLY_AWAKE = 32'h5a5a0001;  // Arbitrary value
    localparam logic [4:0] REPLY_LAST_BIT = 5'h1f;

endpackage

// ===== hw/pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; output moves when stages two and three agree
module pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic din,
    output logic dout
);
    logic s1_r;         // First stage, read only by second
    logic s2_r;         // Second stage
    logic s3_r;         // Third stage

    // ==========================================================
    // Shift chain and agreement filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            dout <= 1'b1;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule // pin_sync

// ===== hw/sleep_wake_controller.sv
`timescale 1ns/1ps
// Sleep entry, wake source selection and wake-up sequence
module sleep_wake_controller
    import sleep_wake_pkg::*;
#(
    parameter int WAKE_DELAY = WAKE_DELAY_CYCLES    // Oscillator settle count
) (
    // System clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Serial link pins
    input wire logic LINK_CLK,
    input wire logic SERIAL_SELECT_N,
    output logic SERIAL_DATA_OUT,
    // Wake pin
    input wire logic WAKE_PIN,
    // Configuration from the host side
    input wire logic CFG_WRITE,
    input wire wake_cfg_s WAKE_CFG,
    input wire logic [MODE_W-1:0] MODE_CFG,
    input wire logic [15:0] SLEEP_TIME,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SELECT,
    // Working data
    input wire logic [31:0] CONFIG_IN,
    input wire logic [63:0] UNIQUE_ID_IN,
    input wire logic [7:0] TEMP_IN,
    input wire logic [7:0] VBAT_IN,
    // Power control
    output logic OSC_ENABLE,
    output logic REGULATOR_ENABLE,
    output logic RESET_OUT_N,
    // Status
    output logic [5:0] STATE,
    output wake_cfg_s WAKE_CFG_OUT,
    output logic [MODE_W-1:0] MODE_OUT,
    // Wake actions and results
    output wake_act_s ACTIONS,
    output logic [31:0] CONFIG_OUT,
    output logic [63:0] UNIQUE_ID_OUT,
    output logic [7:0] TEMP_OUT,
    output logic [7:0] VBAT_OUT
);

    // ==========================================================
    // State encoding
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,        // Awake and idle
        ST_SAVE = 6'h02,        // Copy to always-on store
        ST_SLEEP = 6'h04,       // Light sleep, counter runs
        ST_DEEP = 6'h08,        // Deep sleep, store only
        ST_WAKEUP = 6'h10,      // Oscillator settling
        ST_INIT = 6'h20         // Restore and lock
    } state_e;

    state_e state_r;                    // Current state
    state_e state_nxt;                  // Next state
    logic [TIMER_W-1:0] timer_r;        // Shared phase timer
    logic [TIMER_W-1:0] pin_cnt_r;      // Wake pin high count
    wake_cfg_s wake_r;                  // Held wake sources
    logic [MODE_W-1:0] mode_r;          // Held on-wake options
    logic [15:0] sleep_time_r;          // Held sleep count
    logic [31:0] always_on_store_r;     // Always-on store
    logic select_sync;                  // Select pin, synchronised
    logic select_prev_r;                // Previous select level
    logic pin_sync_lvl;                 // Wake pin, synchronised
    logic select_event;                 // Select went low
    logic pin_event;                    // Wake pin qualified
    logic counter_event;                // Sleep counter expired
    logic wake_event;                   // Any enabled wake
    logic timer_done;                   // Phase timer end
    logic meas_pend_r;                  // Capture results next cycle
    logic deep_flag_r;                  // Deep sleep level for link
    logic deep_link;                    // Deep flag in link domain
    logic [4:0] bit_cnt_r;              // Link bit position
    logic link_rst_n;                   // Link frame reset

    // ==========================================================
    // Pin synchronisers in the system domain
    pin_sync u_select_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .din(SERIAL_SELECT_N),
        .dout(select_sync)
    );

    pin_sync u_pin_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .din(WAKE_PIN),
        .dout(pin_sync_lvl)
    );

    // ==========================================================
    // Select activity detector
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            select_prev_r <= 1'b1;
        end else begin
            select_prev_r <= select_sync;
        end
    end

    // Falling select level marks activity
    assign select_event = select_prev_r && !select_sync;

    // ==========================================================
    // Wake pin qualifier: short pulses never reach the count
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_cnt_r <= '0;
        end else if (!pin_sync_lvl) begin
            // Low level restarts qualification
            pin_cnt_r <= '0;
        end else if (pin_cnt_r != TIMER_W'(WAKE_PIN_CYCLES)) begin
            // Count high time, saturate at the limit
            pin_cnt_r <= pin_cnt_r + 1'b1;
        end
    end

    // High for the full qualify time
    assign pin_event = (pin_cnt_r == TIMER_W'(WAKE_PIN_CYCLES - 1)) && pin_sync_lvl;

    // ==========================================================
    // Wake source selection
    always_comb begin
        // Counter only counts in light sleep
        counter_event = (state_r == ST_SLEEP) && wake_r.wake_on_counter
            && (timer_r[15:0] == sleep_time_r);
        wake_event = counter_event
            || (wake_r.wake_on_pin && pin_event)
            || (wake_r.wake_on_select && select_event);
    end

    // Phase timer end for wake-up and init
    always_comb begin
        if (state_r == ST_WAKEUP) begin
            timer_done = (timer_r == TIMER_W'(WAKE_DELAY - 1));
        end else begin
            timer_done = (timer_r == TIMER_W'(INIT_CYCLES - 1));
        end
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                // Sleep request only counts when allowed
                if (SLEEP_REQ && wake_r.sleep_allow) begin
                    state_nxt = ST_SAVE;
                end
            end
            ST_SAVE: begin
                // Store written, now power down
                state_nxt = DEEP_SELECT ? ST_DEEP : ST_SLEEP;
            end
            ST_SLEEP: begin
                // Any enabled source wakes
                if (wake_event) begin
                    state_nxt = ST_WAKEUP;
                end
            end
            ST_DEEP: begin
                // Stays until an enabled event arrives
                if (wake_event) begin
                    state_nxt = ST_WAKEUP;
                end
            end
            ST_WAKEUP: begin
                // Oscillator settled
                if (timer_done) begin
                    state_nxt = ST_INIT;
                end
            end
            ST_INIT: begin
                // Restore and lock finished
                if (timer_done) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // State code shown to the host side
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            STATE <= ST_IDLE;
        end else begin
            STATE <= state_nxt;
        end
    end

    // ==========================================================
    // Shared timer: restarts on every state change
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            timer_r <= '0;
        end else if (state_nxt != state_r) begin
            timer_r <= '0;
        end else if (state_r == ST_DEEP || state_r == ST_IDLE) begin
            // No counter runs in deep sleep or idle
            timer_r <= '0;
        end else if (timer_r[15:0] != 16'hffff || state_r != ST_SLEEP) begin
            timer_r <= timer_r + 1'b1;
        end
    end

    // ==========================================================
    // Held wake configuration
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_r <= WAKE_CFG_RESET;
            mode_r <= MODE_RESET;
            sleep_time_r <= '0;
        end else if (state_r == ST_IDLE && CFG_WRITE) begin
            // Writes only land while awake and idle
            wake_r <= WAKE_CFG;
            mode_r <= MODE_CFG;
            sleep_time_r <= SLEEP_TIME;
        end else if (state_r == ST_INIT && timer_done
                && !mode_r[MODE_KEEP_SLEEP_SETTINGS]) begin
            // Sleep settings back to reset value unless kept
            wake_r <= WAKE_CFG_RESET;
        end
    end

    // Held configuration visible to the host side
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WAKE_CFG_OUT <= WAKE_CFG_RESET;
            MODE_OUT <= MODE_RESET;
        end else begin
            WAKE_CFG_OUT <= wake_r;
            MODE_OUT <= mode_r;
        end
    end

    // ==========================================================
    // Always-on store: written on the way into sleep
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            always_on_store_r <= '0;
        end else if (state_r == ST_SAVE) begin
            always_on_store_r <= CONFIG_IN;
        end
    end

    // ==========================================================
    // Power control outputs
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            OSC_ENABLE <= 1'b1;
            REGULATOR_ENABLE <= 1'b1;
            RESET_OUT_N <= 1'b1;
        end else begin
            unique case (state_nxt)
                ST_SLEEP, ST_DEEP: begin
                    // Everything off but the store
                    OSC_ENABLE <= 1'b0;
                    REGULATOR_ENABLE <= 1'b0;
                    RESET_OUT_N <= 1'b0;
                end
                ST_WAKEUP: begin
                    // Oscillator first, regulator later
                    OSC_ENABLE <= 1'b1;
                    REGULATOR_ENABLE <= 1'b0;
                    RESET_OUT_N <= 1'b0;
                end
                default: begin
                    // Init, idle and save keep all on
                    OSC_ENABLE <= 1'b1;
                    REGULATOR_ENABLE <= 1'b1;
                    RESET_OUT_N <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Wake action strobes, one cycle each
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACTIONS <= '0;
        end else begin
            ACTIONS <= '0;
            if (state_r == ST_WAKEUP && timer_done) begin
                // First cycle of init
                ACTIONS.trim <= mode_r[MODE_RELOAD_REGULATOR_TRIM];
                ACTIONS.detector <= mode_r[MODE_RELOAD_DETECTOR_CODE];
                ACTIONS.opset <= mode_r[MODE_RELOAD_OPERATING_SET];
                ACTIONS.opset_default <= !mode_r[MODE_RELOAD_OPERATING_SET];
                ACTIONS.config_restore <= mode_r[MODE_RESTORE_CONFIG];
                ACTIONS.unique_id <= mode_r[MODE_RELOAD_UNIQUE_ID];
            end
            if (state_r == ST_INIT && timer_done) begin
                // Last step of the wake-up sequence
                ACTIONS.receive <= mode_r[MODE_RECEIVE_AFTER_WAKE];
                ACTIONS.measure <= mode_r[MODE_MEASURE_AFTER_WAKE];
            end
        end
    end

    // ==========================================================
    // Restored data: configuration and identifier
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CONFIG_OUT <= '0;
            UNIQUE_ID_OUT <= '0;
        end else if (state_r == ST_WAKEUP && timer_done) begin
            if (mode_r[MODE_RESTORE_CONFIG]) begin
                // Store copied back into working registers
                CONFIG_OUT <= always_on_store_r;
            end
            if (mode_r[MODE_RELOAD_UNIQUE_ID]) begin
                // Identifier from one-time memory
                UNIQUE_ID_OUT <= UNIQUE_ID_IN;
            end
        end
    end

    // ==========================================================
    // Measurement capture: results held until the next one
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meas_pend_r <= 1'b0;
            TEMP_OUT <= '0;
            VBAT_OUT <= '0;
        end else begin
            meas_pend_r <= ACTIONS.measure;
            if (meas_pend_r) begin
                TEMP_OUT <= TEMP_IN;
                VBAT_OUT <= VBAT_IN;
            end
        end
    end

    // ==========================================================
    // Deep sleep level handed to the link domain
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            deep_flag_r <= 1'b0;
        end else begin
            deep_flag_r <= (state_nxt == ST_DEEP);
        end
    end

    // Level crossing into the link clock
    pin_sync u_deep_sync (
        .clk(LINK_CLK),
        .rst_n(RST_N),
        .din(deep_flag_r),
        .dout(deep_link)
    );

    // ==========================================================
    // Link-domain reply: frame position ends with the select pin
    assign link_rst_n = RST_N && !SERIAL_SELECT_N;

    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_r <= REPLY_LAST_BIT;
        end else begin
            bit_cnt_r <= bit_cnt_r - 1'b1;
        end
    end

    // Serial data: all ones while in deep sleep
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL_DATA_OUT <= 1'b1;
        end else if (deep_link) begin
            SERIAL_DATA_OUT <= 1'b1;
        end else begin
            SERIAL_DATA_OUT <= REPLY_AWAKE[bit_cnt_r];
        end
    end

endmodule // sleep_wake_controller

// ===== test/sleep_wake_checker_sva.sv
`timescale 1ns/1ps
// Sleep entry and wake-up sequence checker
module sleep_wake_checker
    import sleep_wake_pkg::*;
#(
    parameter int WAKE_DELAY = WAKE_DELAY_CYCLES // Oscillator settle count
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Status
    input wire logic [5:0] STATE,
    input wire wake_cfg_s WAKE_CFG_OUT,
    input wire logic [MODE_W-1:0] MODE_OUT,
    input wire wake_act_s ACTIONS,
    // Power outputs
    input wire logic OSC_ENABLE,
    input wire logic REGULATOR_ENABLE,
    input wire logic RESET_OUT_N
);
    // ======
    // Phase counters
    logic [15:0] wake_cnt_r; // Cycles spent in wake-up
    logic [15:0] init_cnt_r; // Cycles spent in init
    // Count consecutive cycles of each phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_cnt_r <= '0;
            init_cnt_r <= '0;
        end else begin
            wake_cnt_r <= (STATE == 6'h10) ? wake_cnt_r + 1'b1 : '0;
            init_cnt_r <= (STATE == 6'h20) ? init_cnt_r + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ======
    // Properties
    a_sleep_needs_allow: assert property (STATE == 6'h02 |-> WAKE_CFG_OUT.sleep_allow)
        else $error("sleep without allow");
    a_save_then_sleep: assert property (STATE == 6'h02 |=> STATE inside {6'h04, 6'h08})
        else $error("no sleep after save");
    a_asleep_power_off: assert property (STATE[3:2] != 2'b00
        |-> !OSC_ENABLE && !REGULATOR_ENABLE && !RESET_OUT_N)
        else $error("power on in sleep");
    a_wakeup_osc_on: assert property (STATE == 6'h10
        |-> OSC_ENABLE && !REGULATOR_ENABLE && !RESET_OUT_N)
        else $error("wake-up power wrong");
    a_wakeup_delay_len: assert property (STATE == 6'h20 && $past(STATE) == 6'h10
        |-> wake_cnt_r == 16'(WAKE_DELAY))
        else $error("settle time wrong");
    a_init_restore_len: assert property (STATE == 6'h01 && $past(STATE) == 6'h20
        |-> init_cnt_r == 16'(INIT_CYCLES))
        else $error("init length wrong");
    a_init_reset_high: assert property (STATE == 6'h20
        |-> RESET_OUT_N && REGULATOR_ENABLE ##1 (STATE == 6'h20 || STATE == 6'h01))
        else $error("init outputs wrong");
    a_load_pulses: assert property ($rose(STATE == 6'h20)
        |-> ACTIONS.trim == MODE_OUT[MODE_RELOAD_REGULATOR_TRIM]
        && ACTIONS.detector == MODE_OUT[MODE_RELOAD_DETECTOR_CODE])
        else $error("load pulses wrong");
    a_opset_choice: assert property ($rose(STATE == 6'h20)
        |-> ACTIONS.opset == MODE_OUT[7] && ACTIONS.opset_default != MODE_OUT[7])
        else $error("opset choice wrong");
    a_final_steps: assert property (STATE == 6'h01 && $past(STATE) == 6'h20
        |-> ACTIONS.receive == MODE_OUT[1] && ACTIONS.measure == MODE_OUT[0])
        else $error("final pulses wrong");
    // Main scenarios reached
    c_light_wake: cover property (STATE == 6'h04 ##1 STATE == 6'h10);
    c_deep_wake: cover property (STATE == 6'h08 ##1 STATE == 6'h10);
    c_back_idle: cover property (STATE == 6'h20 ##1 STATE == 6'h01);
endmodule // sleep_wake_checker

// ===== test/host_link_model.sv
`timescale 1ns/1ps
// Host side: serial frames and wake pin
module host_link_model (
    // Link pins
    output logic link_clk,
    output logic select_n,
    output logic wake_pin,
    input wire logic data_in
);
    // Idle levels, link clock stands still
    initial begin
        link_clk = 1'b0;
        select_n = 1'b1;
        wake_pin = 1'b0;
    end
    // Wake pin level
    task automatic set_pin(input logic v);
        wake_pin = v;
    endtask
    // One frame of 32 bits, msb first, 32 ns link period
    task automatic read_word(output logic [31:0] w); // Used for both deep sleep and awake frames
        #16 select_n = 1'b0;
        #7;
        for (int i = 0; i < 32; i++) begin
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
            w = {w[30:0], data_in};
        end
        #16 select_n = 1'b1;
    endtask
endmodule // host_link_model

// ===== test/test_sleep_wake_controller.sv
`timescale 1ns/1ps
// Sleep and wake-up controller bench
module test_sleep_wake_controller
    import sleep_wake_pkg::*;
;
    // ======
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_clk, sel_n, wake_pin, data_out, osc_en, reg_en, rst_out_n;
    logic cfg_write = 1'b0, sleep_req = 1'b0, deep_sel = 1'b0;
    wake_cfg_s wake_cfg = 4'h8;
    wake_cfg_s wake_cfg_out;
    wake_act_s actions;
    logic [12:0] mode_cfg = 13'h0000;
    logic [12:0] mode_out;
    logic [15:0] sleep_time = 16'h0010;
    logic [31:0] config_in = 32'hc3a50f17;
    logic [63:0] uid_in = 64'h0123456789abcdef; // Arbitrary identifier
    logic [7:0] temp_in = 8'h2c, vbat_in = 8'hb7;
    logic [5:0] state;
    logic [31:0] config_out, word;
    logic [63:0] uid_out;
    logic [7:0] temp_out, vbat_out;
    int n_mismatch = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    sleep_wake_controller #(.WAKE_DELAY(20)) i_sleep_wake_controller (
        .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .SERIAL_SELECT_N(sel_n),
        .SERIAL_DATA_OUT(data_out), .WAKE_PIN(wake_pin), .CFG_WRITE(cfg_write),
        .WAKE_CFG(wake_cfg), .MODE_CFG(mode_cfg), .SLEEP_TIME(sleep_time),
        .SLEEP_REQ(sleep_req), .DEEP_SELECT(deep_sel), .CONFIG_IN(config_in),
        .UNIQUE_ID_IN(uid_in), .TEMP_IN(temp_in), .VBAT_IN(vbat_in), .OSC_ENABLE(osc_en),
        .REGULATOR_ENABLE(reg_en), .RESET_OUT_N(rst_out_n), .STATE(state),
        .WAKE_CFG_OUT(wake_cfg_out), .MODE_OUT(mode_out), .ACTIONS(actions),
        .CONFIG_OUT(config_out), .UNIQUE_ID_OUT(uid_out), .TEMP_OUT(temp_out),
        .VBAT_OUT(vbat_out));
    host_link_model i_host_link_model (
        .link_clk(link_clk), .select_n(sel_n), .wake_pin(wake_pin), .data_in(data_out));
    // ======
    // Shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Wait cycles, then let the edge settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait for a state
    task automatic wait_state(input logic [5:0] s, input int lim);
        for (int i = 0; i < lim && state !== s; i++) cyc(1);
        check(state, s);
        if (state !== s) complete_run();
    endtask
    // Settings always written while idle, before sleep
    task automatic configure(input logic [3:0] w, input logic [12:0] m, input logic [15:0] t);
        @(posedge clk);
        cfg_write <= 1'b1;
        wake_cfg <= w;
        mode_cfg <= m;
        sleep_time <= t;
        @(posedge clk);
        cfg_write <= 1'b0;
        cyc(2);
        check(wake_cfg_out, w);
        check(mode_out, m);
    endtask
    task automatic go_sleep(input logic deep);
        @(posedge clk);
        sleep_req <= 1'b1;
        deep_sel <= deep;
        @(posedge clk);
        sleep_req <= 1'b0;
    endtask
    // ======
    // Scenarios
    task automatic sc_refuse;
        check(wake_cfg_out, 4'h8);
        configure(4'h8, 13'h0000, 16'h0010);
        go_sleep(1'b0);
        cyc(20);
        check(state, 6'h01);
    endtask
    task automatic sc_counter;
        configure(4'h9, 13'h18cb, 16'h0040);
        go_sleep(1'b0);
        wait_state(6'h04, 4);
        config_in <= ~config_in;
        wait_state(6'h10, 80);
        wait_state(6'h20, 40);
        check(config_out, 32'(~config_in));
        check(uid_out, uid_in);
        wait_state(6'h01, 4100);
        cyc(4);
        check(temp_out, 8'h2c);
        check(vbat_out, 8'hb7);
        check(wake_cfg_out, 4'h8);
    endtask
    task automatic sc_pin;
        {temp_in, vbat_in} <= 16'h0;
        configure(4'h3, 13'h0100, 16'h0010);
        go_sleep(1'b0);
        cyc(200);
        check(state, 6'h04);
        i_host_link_model.set_pin(1'b1);
        cyc(50);
        i_host_link_model.set_pin(1'b0);
        cyc(20);
        check(state, 6'h04);
        i_host_link_model.set_pin(1'b1);
        wait_state(6'h10, 120);
        i_host_link_model.set_pin(1'b0);
        wait_state(6'h01, 4100);
        check(wake_cfg_out, 4'h3);
        check({temp_out, vbat_out}, 16'h2cb7);
    endtask
    task automatic sc_deep;
        configure(4'hb, 13'h0000, 16'h0010);
        go_sleep(1'b1);
        wait_state(6'h08, 4);
        i_host_link_model.read_word(word);
        i_host_link_model.read_word(word);
        check(word, REPLY_ASLEEP);
        check(state, 6'h08);
        i_host_link_model.set_pin(1'b1);
        wait_state(6'h10, 120);
        i_host_link_model.set_pin(1'b0);
        wait_state(6'h01, 4100);
        i_host_link_model.read_word(word);
        i_host_link_model.read_word(word);
        check(word, REPLY_AWAKE);
    endtask
    task automatic sc_select;
        configure(4'h5, 13'h0000, 16'h0010);
        go_sleep(1'b1);
        wait_state(6'h08, 4);
        i_host_link_model.read_word(word);
        check(state, 6'h20);
        wait_state(6'h01, 4100);
    endtask
    // Main sequence, reset only at start
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        sc_refuse();
        sc_counter();
        sc_pin();
        sc_deep();
        sc_select();
        complete_run();
    end
endmodule // test_sleep_wake_controller
bind sleep_wake_controller sleep_wake_checker #(.WAKE_DELAY(WAKE_DELAY)) i_sleep_wake_checker (
    .CLK(CLK), .RST_N(RST_N), .STATE(STATE), .WAKE_CFG_OUT(WAKE_CFG_OUT),
    .MODE_OUT(MODE_OUT), .ACTIONS(ACTIONS), .OSC_ENABLE(OSC_ENABLE),
    .REGULATOR_ENABLE(REGULATOR_ENABLE), .RESET_OUT_N(RESET_OUT_N));
